// >>> mpb_pkg.sv
/*
 * Constants, field layout, types and helpers of the motor PWM unit
 * with brake inputs and dead time. Assumes an APB master with 32-bit
 * data and byte addresses that use the low eight bits.
 */
// What this block does
// - count up from zero; even output low at duty
// - reverse at period; even output high at duty
// - underflow with load bit copies holding registers
// - period request at underflow or period match
// - two brake inputs, four-setting filter each
// - brake zero falling edge sets flag zero
// - brake zero drives level bits through polarity
// - brake zero clears run bit
// - brake zero holds until run and next period
// - brake one falling edge sets flag one
// - auto brake one low drives level bits
// - brake one leaves run bit set
// - brake one released at next period start
// - brake acts only when its enable set
// - tri-state bits float even or odd outputs
// - tri-state bits loaded from configuration at first edge after reset
// - independent mode, output six and seven sources
// - complementary mode inverts odd from even
// - dead time delays turn-on by count plus one
// - dead-time writes need timed access sequence
// - synchronous mode copies even to odd
// - group mode makes all pairs follow generator zero
// - period and duty double buffered by load bit
package mpb_pkg;

  // ---------------------------------------------------------------
  // widths and register offsets
  // ---------------------------------------------------------------
  localparam int CNT_W = 12;               // time-base width
  localparam logic [7:0] OFS_CTRL = 8'h00; // control word
  localparam logic [7:0] OFS_PER = 8'h04;  // period holding
  localparam logic [7:0] OFS_DUTY = 8'h08; // duty 0..3 at 08..14
  localparam logic [7:0] OFS_BRK = 8'h18;  // brake levels, polarity
  localparam logic [7:0] OFS_STAT = 8'h1c; // flags and counter
  localparam logic [7:0] OFS_DT = 8'h20;   // dead time, protected
  localparam logic [7:0] OFS_TA = 8'h24;   // timed-access key

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_RUN = 0;
  localparam int CTL_LOAD = 1;
  localparam int CTL_ITYPE = 2;
  localparam int CTL_MODE = 3;   // two bits
  localparam int CTL_GRP = 5;
  localparam int CTL_OUT6 = 6;
  localparam int CTL_AUTO1 = 7;
  localparam int CTL_BKEN = 8;   // two bits, one per input
  localparam int CTL_HZE = 10;
  localparam int CTL_HZO = 11;
  localparam int CTL_FILT = 12;  // two bits per input
  localparam int BRK_LVL = 0;    // six bits
  localparam int BRK_POL = 8;    // six bits
  localparam int ST_FLAG = 0;    // two bits, write one to clear
  localparam int ST_HOLD = 2;    // two bits
  localparam int ST_DIR = 4;
  localparam int ST_TAOPEN = 5;
  localparam int ST_CNT = 16;
  localparam int DT_CNT = 0;     // eight bits
  localparam int DT_EN = 8;

  // ---------------------------------------------------------------
  // reset values and keys
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_f3fe;
  localparam logic [CNT_W-1:0] PER_RST = 12'hfff;
  localparam logic [CNT_W-1:0] DUTY_RST = 12'h000;
  localparam logic [8:0] DT_RST = 9'h000;
  localparam logic [11:0] BRK_RST = 12'h000;
  localparam logic [1:0] HZ_RST = 2'h3;
  localparam logic [7:0] TA_KEY1 = 8'haa;
  localparam logic [7:0] TA_KEY2 = 8'h55;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IND = 2'h0,
    MODE_COMP = 2'h1,
    MODE_SYNC = 2'h2,
    MODE_GRP = 2'h3
  } mpb_mode_e;

  typedef enum logic [2:0] {
    TA_IDLE = 3'h1,
    TA_KEY = 3'h2,
    TA_OPEN = 3'h4
  } mpb_ta_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mpb_apb_s;

  // samples a new brake level needs before it is believed
  function automatic logic [3:0] filt_need(input logic [1:0] sel);
    filt_need = 4'h1 << sel;
  endfunction : filt_need

endpackage : mpb_pkg

// >>> mpb_pwm.sv
/*
 * Center-aligned motor PWM unit: time base, four duty generators,
 * pairing modes with dead time, two filtered brake inputs, polarity
 * and tri-state control, APB register slave.
 * Assumes brake and configuration inputs synchronous to mclk and a
 * prescale of one (one count per mclk).
 */
module mpb_pwm
  import mpb_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire mpb_apb_s apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic brake_in_zero,
  input wire logic brake_in_one,
  input wire logic cfg_tristate_even,
  input wire logic cfg_tristate_odd,
  output logic [7:0] pwm_out,
  output logic [7:0] pwm_oe,
  output logic period_req
);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic setup = apb_req.psel & ~apb_req.penable;
  wire logic acc = apb_req.psel & apb_req.penable;
  wire logic [7:0] addr = apb_req.paddr;
  wire logic [31:0] wd = apb_req.pwdata;
  wire logic is_duty = addr >= OFS_DUTY && addr < OFS_BRK && addr[1:0] == 2'h0;
  wire logic mapped = addr == OFS_CTRL || addr == OFS_PER || is_duty ||
                      addr == OFS_BRK || addr == OFS_STAT || addr == OFS_DT ||
                      addr == OFS_TA;
  wire logic wr = acc & apb_req.pwrite & mapped;
  wire logic wr_ctrl = wr && addr == OFS_CTRL;
  wire logic wr_stat = wr && addr == OFS_STAT;
  wire logic [1:0] duty_idx = 2'(addr[3:2] - 2'h2);

  assign pready = acc;                // zero wait states
  assign pslverr = acc & ~mapped;     // unmapped: error, no effect

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;              // software control word
  logic run_reg;                      // run bit, hardware clearable
  logic run_d_reg;                    // run one cycle back
  logic [1:0] hz_reg;                 // {odd, even} tri-state
  logic cfg_done_reg;                 // configuration captured
  logic [CNT_W-1:0] per_hold_reg;     // software-side period
  logic [CNT_W-1:0] per_act_reg;      // period in use
  logic [CNT_W-1:0] duty_hold_reg [4];
  logic [CNT_W-1:0] duty_act_reg [4];
  logic [11:0] brk_reg;               // {polarity, levels}
  logic [8:0] dt_reg;                 // {enable, count}
  mpb_ta_e ta_reg;                    // timed-access state
  logic [1:0] flag_reg;               // brake flags
  logic [31:0] prdata_reg;

  wire mpb_mode_e mode = mpb_mode_e'(ctrl_reg[CTL_MODE +: 2]);
  wire logic load_bit = ctrl_reg[CTL_LOAD];
  wire logic [1:0] bken = ctrl_reg[CTL_BKEN +: 2];
  wire logic [5:0] lvl = brk_reg[BRK_LVL +: 6];
  wire logic [5:0] pol = brk_reg[11:6];
  wire logic dt_on = dt_reg[DT_EN];
  wire logic [7:0] dt_cnt = dt_reg[DT_CNT +: 8];

  // ---------------------------------------------------------------
  // brake filters and edge detect
  // ---------------------------------------------------------------
  logic [1:0] filt_reg;               // believed brake levels
  logic [1:0] filt_d_reg;             // believed levels, one back
  logic [3:0] fcnt_reg [2];           // agreeing sample counters
  wire logic [1:0] braw = {brake_in_one, brake_in_zero};
  wire logic [1:0] fall = filt_d_reg & ~filt_reg;

  // a level must persist 1, 2, 4 or 8 samples to pass
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      filt_reg <= 2'h3;
      filt_d_reg <= 2'h3;
      fcnt_reg <= '{default: 4'h0};
    end else begin
      filt_d_reg <= filt_reg;
      for (int i = 0; i < 2; i++) begin
        if (braw[i] == filt_reg[i]) begin
          fcnt_reg[i] <= 4'h0;
        end else if (4'(fcnt_reg[i] + 4'h1) >=
                     filt_need(ctrl_reg[CTL_FILT + 2*i +: 2])) begin
          filt_reg[i] <= braw[i];
          fcnt_reg[i] <= 4'h0;
        end else begin
          fcnt_reg[i] <= 4'(fcnt_reg[i] + 4'h1);
        end
      end
    end
  end

  wire logic brk0_evt = fall[0] & bken[0];
  wire logic brk1_act = ctrl_reg[CTL_AUTO1] & bken[1] & ~filt_reg[1];

  // flags: a new edge beats a software clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 2'h0;
    end else begin
      flag_reg <= fall | (flag_reg & ~({2{wr_stat}} & wd[ST_FLAG +: 2]));
    end
  end

  // ---------------------------------------------------------------
  // control, run bit and tri-state
  // ---------------------------------------------------------------
  // brake zero wins over a software run write in the same cycle
  wire logic run_next = brk0_evt ? 1'b0 :
                        wr_ctrl ? wd[CTL_RUN] : run_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= CTRL_RST;
      run_reg <= 1'b0;
      run_d_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      run_d_reg <= run_reg;
      if (wr_ctrl) begin
        ctrl_reg <= wd & CTRL_MASK;
      end
    end
  end

  // async reset floats the pins; the strap levels come in at the
  // first edge after release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hz_reg <= HZ_RST;
      cfg_done_reg <= 1'b0;
    end else if (!cfg_done_reg) begin
      hz_reg <= {cfg_tristate_odd, cfg_tristate_even};
      cfg_done_reg <= 1'b1;
    end else if (wr_ctrl) begin
      hz_reg <= {wd[CTL_HZO], wd[CTL_HZE]};
    end
  end

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg;          // up/down counter
  logic dir_dn_reg;                   // one while counting down
  wire logic run_rise = run_reg & ~run_d_reg;
  wire logic underflow = run_reg & dir_dn_reg & cnt_reg == '0;
  wire logic up_match = run_reg & ~dir_dn_reg & cnt_reg == per_act_reg;
  wire logic do_load = run_rise | (underflow & load_bit);

  // idle holds zero so each start counts up from zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      dir_dn_reg <= 1'b0;
    end else if (!run_reg) begin
      cnt_reg <= '0;
      dir_dn_reg <= 1'b0;
    end else if (up_match) begin
      cnt_reg <= CNT_W'(cnt_reg - 1'b1);
      dir_dn_reg <= 1'b1;
    end else if (underflow) begin
      cnt_reg <= CNT_W'(1);
      dir_dn_reg <= 1'b0;
    end else begin
      cnt_reg <= dir_dn_reg ? CNT_W'(cnt_reg - 1'b1) : CNT_W'(cnt_reg + 1'b1);
    end
  end

  // holding registers and transfer to the active set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      per_hold_reg <= PER_RST;
      per_act_reg <= PER_RST;
      duty_hold_reg <= '{default: DUTY_RST};
      duty_act_reg <= '{default: DUTY_RST};
    end else begin
      if (wr && addr == OFS_PER) begin
        per_hold_reg <= wd[CNT_W-1:0];
      end
      if (wr && is_duty) begin
        duty_hold_reg[duty_idx] <= wd[CNT_W-1:0];
      end
      if (do_load) begin
        per_act_reg <= per_hold_reg;
        duty_act_reg <= duty_hold_reg;
      end
    end
  end

  // period request pulse: underflow or top match by type bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      period_req <= 1'b0;
    end else begin
      period_req <= ctrl_reg[CTL_ITYPE] ? up_match : underflow;
    end
  end

  // ---------------------------------------------------------------
  // duty generators
  // ---------------------------------------------------------------
  logic [3:0] gen_reg;                // generator levels, 0..3
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gen_reg <= 4'hf;
    end else begin
      for (int g = 0; g < 4; g++) begin
        if (!run_reg) begin
          gen_reg[g] <= 1'b1;
        end else if (cnt_reg == duty_act_reg[g]) begin
          gen_reg[g] <= dir_dn_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pairing modes and dead time
  // ---------------------------------------------------------------
  wire logic group_bit = mode == MODE_GRP && ctrl_reg[CTL_GRP];
  wire logic comp = mode == MODE_COMP || group_bit;
  wire logic [3:0] src = group_bit ? {4{gen_reg[0]}} : gen_reg;
  logic [2:0] src_d_reg;              // even sources, one back
  logic [2:0] busy_reg;               // dead time running per pair
  logic [7:0] dcnt_reg [3];           // dead-time down counters
  logic [7:0] pg;                     // internal pair signals

  // a change of the even source blanks both outputs of the pair
  // for count plus one cycles; turn-off is never delayed
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      src_d_reg <= 3'h7;
      busy_reg <= 3'h0;
      dcnt_reg <= '{default: 8'h00};
    end else begin
      src_d_reg <= src[2:0];
      for (int k = 0; k < 3; k++) begin
        if (src[k] != src_d_reg[k]) begin
          // the change cycle itself is the first blank cycle
          busy_reg[k] <= comp & dt_on & (dt_cnt != 8'h00);
          dcnt_reg[k] <= 8'(dt_cnt - 8'h01);
        end else if (busy_reg[k]) begin
          busy_reg[k] <= dcnt_reg[k] != 8'h00;
          dcnt_reg[k] <= 8'(dcnt_reg[k] - 8'h01);
        end
      end
    end
  end

  // blanking starts in the very cycle the source moves, so the new
  // level never leaks through to the switches for one cycle
  wire logic [2:0] blank = busy_reg | ({3{comp & dt_on}} & (src[2:0] ^ src_d_reg));

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      pg[2*k] = src[k] & ~blank[k];
      if (comp) begin
        pg[2*k+1] = ~src[k] & ~blank[k];
      end else if (mode == MODE_SYNC) begin
        pg[2*k+1] = src[k];
      end else begin
        pg[2*k+1] = 1'b0;
      end
    end
    pg[6] = ctrl_reg[CTL_OUT6] ? src[1] : src[3];
    pg[7] = src[2];
  end

  // ---------------------------------------------------------------
  // brake hold and output stage
  // ---------------------------------------------------------------
  logic b0_hold_reg;                  // brake zero in force
  logic b1_hold_reg;                  // brake one in force
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      b0_hold_reg <= 1'b0;
      b1_hold_reg <= 1'b0;
    end else begin
      if (brk0_evt) begin
        b0_hold_reg <= 1'b1;
      end else if (underflow) begin
        b0_hold_reg <= 1'b0;
      end
      if (brk1_act) begin
        b1_hold_reg <= 1'b1;
      end else if (underflow) begin
        b1_hold_reg <= 1'b0;
      end
    end
  end

  wire logic brk = b0_hold_reg | b1_hold_reg;
  wire logic [7:0] out_next = {pg[7:6], (brk ? lvl : pg[5:0]) ^ pol};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_out <= 8'h00;
    end else begin
      pwm_out <= out_next;
    end
  end

  assign pwm_oe = {4{~hz_reg[1], ~hz_reg[0]}};

  // ---------------------------------------------------------------
  // brake setup and timed-access dead-time register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      brk_reg <= BRK_RST;
      dt_reg <= DT_RST;
      ta_reg <= TA_IDLE;
    end else begin
      if (wr && addr == OFS_BRK) begin
        brk_reg <= {wd[BRK_POL +: 6], wd[BRK_LVL +: 6]};
      end
      if (wr && addr == OFS_DT && ta_reg == TA_OPEN) begin
        dt_reg <= wd[8:0];
      end
      if (wr) begin
        unique case (ta_reg)
          TA_IDLE: ta_reg <= (addr == OFS_TA && wd[7:0] == TA_KEY1) ? TA_KEY : TA_IDLE;
          TA_KEY: ta_reg <= (addr == OFS_TA && wd[7:0] == TA_KEY2) ? TA_OPEN : TA_IDLE;
          TA_OPEN: ta_reg <= TA_IDLE;     // one write only
          default: ta_reg <= TA_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read data, captured in the setup cycle
  // ---------------------------------------------------------------
  wire logic [31:0] stat_word = {4'h0, cnt_reg, 10'h000, ta_reg == TA_OPEN,
                                 dir_dn_reg, b1_hold_reg, b0_hold_reg, flag_reg};
  wire logic [31:0] ctrl_word = {ctrl_reg[31:12], hz_reg, ctrl_reg[9:1], run_reg};
  wire logic [31:0] rd_mux =
      addr == OFS_CTRL ? ctrl_word :
      addr == OFS_PER ? {20'h0, per_hold_reg} :
      is_duty ? {20'h0, duty_hold_reg[duty_idx]} :
      addr == OFS_BRK ? {18'h0, brk_reg[11:6], 2'h0, brk_reg[5:0]} :
      addr == OFS_STAT ? stat_word :
      addr == OFS_DT ? {23'h0, dt_reg} : 32'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg <= 32'h0;
    end else if (setup) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_BRK0_STOP: assert property (@(posedge mclk) disable iff (!arst_n)
    brk0_evt |=> !run_reg && b0_hold_reg) else $error("brake zero did not stop");
  AST_FLAG0: assert property (@(posedge mclk) disable iff (!arst_n)
    fall[0] |=> flag_reg[0]) else $error("flag zero not set");
  AST_FLAG1: assert property (@(posedge mclk) disable iff (!arst_n)
    fall[1] |=> flag_reg[1]) else $error("flag one not set");
  AST_TURN: assert property (@(posedge mclk) disable iff (!arst_n)
    up_match |=> dir_dn_reg && cnt_reg == $past(per_act_reg) - 1'b1)
    else $error("no reversal at period");
  AST_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
    underflow && load_bit |=> per_act_reg == $past(per_hold_reg))
    else $error("period not loaded");
  AST_IREQ: assert property (@(posedge mclk) disable iff (!arst_n)
    period_req |-> $past(ctrl_reg[CTL_ITYPE] ? up_match : underflow))
    else $error("stray period request");
  AST_DEAD: assert property (@(posedge mclk) disable iff (!arst_n)
    comp && dt_on |-> !(pg[0] && pg[1]) && (src[0] == src_d_reg[0] || pg[1:0] == 2'h0))
    else $error("pair overlap or turn-on not delayed");
  AST_B1OUT: assert property (@(posedge mclk) disable iff (!arst_n)
    b1_hold_reg |=> pwm_out[5:0] == $past(lvl ^ pol)) else $error("brake level");
  AST_B1RUN: assert property (@(posedge mclk) disable iff (!arst_n)
    brk1_act && run_reg && !brk0_evt && !wr_ctrl |=> run_reg)
    else $error("brake one stopped run");
  AST_STRAP: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(cfg_done_reg) |-> hz_reg == $past({cfg_tristate_odd, cfg_tristate_even}))
    else $error("strap not taken");

endmodule : mpb_pwm

// >>> mpb_stage.sv
/*
 * power stage and brake sources at the far side of the pwm unit.
 * assumes brake trips commanded by the bench, synchronous to mclk.
 */
module mpb_stage
  import mpb_pkg::*;
(
  input wire logic mclk,
  input wire logic trip0,
  input wire logic trip1,
  input wire logic [7:0] pwm_out,
  input wire logic [7:0] pwm_oe,
  output logic brake_in_zero,
  output logic brake_in_one,
  output logic [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_lvl; // level each pin showed last cycle
  initial begin
    brake_in_zero = 1'b1;
    brake_in_one = 1'b1;
    last_lvl = 8'h00;
  end
  // brake lines pulled up, pulled low only while tripped
  always @(posedge mclk) begin
    brake_in_zero <= ~trip0;
    brake_in_one <= ~trip1;
    last_lvl <= pin_lvl;
  end
  // floating pins have no pull, so show the inverse of the last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_lvl[i] = pwm_oe[i] ? pwm_out[i] : ~last_lvl[i];
    end
  end
endmodule : mpb_stage

// >>> mpb_pwm_test.sv
/*
 * self-checking bench of the pwm unit: apb reads noted in a queue,
 * pwm waveform, brake and dead-time scenarios.
 * assumes zero-wait apb slave and straps even=0, odd=1.
 */
module mpb_pwm_test
  import mpb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  mpb_apb_s apb_req = '0;
  logic pready, pslverr, period_req;
  logic [31:0] prdata;
  logic brake_in_zero, brake_in_one;
  logic trip0 = 1'b0;
  logic trip1 = 1'b0;
  logic [7:0] pwm_out, pwm_oe, pin_lvl;
  logic [32:0] q_exp[$]; // expected {pslverr, prdata}, masked
  logic [32:0] q_msk[$]; // bits that matter
  int n_mismatch = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'd50;
  logic [5:0] lvl, pol;
  always #2.5 mclk = ~mclk;

  mpb_pwm i_dut (.mclk(mclk), .arst_n(arst_n), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .brake_in_zero(brake_in_zero),
    .brake_in_one(brake_in_one), .cfg_tristate_even(1'b0), .cfg_tristate_odd(1'b1),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .period_req(period_req));
  mpb_stage i_stage (.mclk(mclk), .trip0(trip0), .trip1(trip1), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .brake_in_zero(brake_in_zero), .brake_in_one(brake_in_one),
    .pin_lvl(pin_lvl));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // one apb transfer; held until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!pready && n < 20);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (!pready) begin
      n_mismatch++;
      complete_run();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    q_exp.push_back(e & m);
    q_msk.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // waits for a period request, then counts low cycles of one output
  task automatic measure(input int ch, input int exp_low);
    int n, lows, reqs;
    n = 0;
    lows = 0;
    reqs = 0;
    // settle first: a mode or brake change just made must not spill in
    repeat (4) @(posedge mclk);
    do begin
      @(posedge mclk);
      n++;
    end while (!period_req && n < 100);
    if (!period_req) begin
      n_mismatch++;
      complete_run();
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      #1;
      lows += int'(!pwm_out[ch]);
      reqs += int'(period_req);
    end
    chk("low", lows, exp_low);
    chk("req", reqs, 1);
  endtask : measure

  // ----------------------------------------------------------------
  // read watcher: oldest note against the access-cycle answer
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (apb_req.psel && apb_req.penable && pready && !apb_req.pwrite && q_exp.size() > 0) begin
      chk("read", {pslverr, prdata} & q_msk.pop_front(), q_exp.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("oe", pwm_oe, 8'h55);
    rd(OFS_CTRL, 33'h800, '1);
    rd(OFS_PER, 33'hfff, '1);
    rd(8'h40, 33'h1_0000_0000, '1);
    apb(1'b1, OFS_PER, 32'h8);
    apb(1'b1, OFS_DUTY, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h803);
    measure(0, 10);
    apb(1'b1, OFS_DUTY, 32'h5);
    apb(1'b1, OFS_CTRL, 32'h807);
    repeat (40) @(posedge mclk);
    measure(0, 6);
    seed = xs(seed);
    lvl = seed[5:0];
    pol = seed[13:8];
    apb(1'b1, OFS_BRK, {18'h0, pol, 2'h0, lvl});
    apb(1'b1, OFS_CTRL, 32'h903);
    trip0 <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk("brk0", pwm_out[5:0], lvl ^ pol);
    rd(OFS_CTRL, 33'h0, 33'h1);
    rd(OFS_STAT, 33'h1, 33'h1);
    trip0 <= 1'b0;
    apb(1'b1, OFS_STAT, 32'h1);
    rd(OFS_STAT, 33'h0, 33'h1);
    repeat (40) @(posedge mclk);
    #1 chk("hold", pwm_out[5:0], lvl ^ pol);
    apb(1'b1, OFS_CTRL, 32'ha83);
    repeat (40) @(posedge mclk);
    trip1 <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk("brk1", pwm_out[5:0], lvl ^ pol);
    rd(OFS_CTRL, 33'h1, 33'h1);
    rd(OFS_STAT, 33'h2, 33'h2);
    trip1 <= 1'b0;
    measure(0, pol[0] ? 10 : 6);
    apb(1'b1, OFS_DT, 32'h1ff);
    rd(OFS_DT, 33'h0, 33'h1ff);
    apb(1'b1, OFS_TA, 32'haa);
    apb(1'b1, OFS_TA, 32'h55);
    apb(1'b1, OFS_DT, 32'h1ff);
    rd(OFS_DT, 33'h1ff, 33'h1ff);
    apb(1'b1, OFS_CTRL, 32'h803);
    trip0 <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(OFS_CTRL, 33'h1, 33'h1);
    trip0 <= 1'b0;
    // dead time of two counts: three blank cycles after each source change
    apb(1'b1, OFS_TA, 32'haa);
    apb(1'b1, OFS_TA, 32'h55);
    apb(1'b1, OFS_DT, 32'h102);
    apb(1'b1, OFS_CTRL, 32'h80b);
    measure(0, pol[0] ? 7 : 9);
    measure(1, pol[1] ? 3 : 13);
    apb(1'b1, OFS_CTRL, 32'h813);
    measure(1, pol[1] ? 10 : 6);
    apb(1'b1, OFS_CTRL, 32'h83b);
    measure(2, pol[2] ? 7 : 9);
    complete_run();
  end
endmodule : mpb_pwm_test
